// ===== rtl/ppx_apb_regs.sv
`timescale 1ns/1ps
module ppx_apb_regs
   import ppx_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Register fields
   output logic [31:0] ctrl_q,
   output logic [31:0] fen_q,
   output logic [31:0] skip_q,
   output logic [31:0] mask_q,
   input wire logic [31:0] stat_in,
   input wire logic [31:0] irq_in,
   input wire logic [31:0] map_in,
   output logic irq_rd
);
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_d;

   function automatic logic known(input logic [7:0] a);
      known = (a == PPX_OFS_CTRL) || (a == PPX_OFS_FEN) || (a == PPX_OFS_SKIP)
         || (a == PPX_OFS_STAT) || (a == PPX_OFS_IRQ) || (a == PPX_OFS_MASK)
         || (a == PPX_OFS_MAP0);
   endfunction

   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pslverr = psel && penable && !known(paddr);
   assign irq_rd = rd_en && (paddr == PPX_OFS_IRQ);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= PPX_RST_CTRL;
         fen_q <= PPX_RST_FEN;
         skip_q <= PPX_RST_SKIP;
         mask_q <= PPX_RST_MASK;
      end else if (wr_en) begin
         if (paddr == PPX_OFS_CTRL) ctrl_q <= pwdata & 32'h0000_000f;
         if (paddr == PPX_OFS_FEN) fen_q <= pwdata & 32'h0000_00ff;
         if (paddr == PPX_OFS_SKIP) skip_q <= pwdata & 32'h0000_ffff;
         if (paddr == PPX_OFS_MASK) mask_q <= pwdata & 32'h0000_0007;
      end
   end

   always_comb begin
      unique case (paddr)
         PPX_OFS_CTRL: rd_d = ctrl_q;
         PPX_OFS_FEN: rd_d = fen_q;
         PPX_OFS_SKIP: rd_d = skip_q;
         PPX_OFS_STAT: rd_d = stat_in;
         PPX_OFS_IRQ: rd_d = irq_in;
         PPX_OFS_MASK: rd_d = mask_q;
         PPX_OFS_MAP0: rd_d = map_in;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Read data registered in the setup phase so it is stable in access
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite) prdata <= rd_d;
   end
endmodule

// ===== rtl/ppx_crossbar.sv
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module ppx_crossbar
   import ppx_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial port
   input wire logic ser_tx,
   output logic ser_rx,
   // Peripheral functions (out, enable low, in)
   input wire logic [PPX_NFUNC-1:0] fn_out,
   input wire logic [PPX_NFUNC-1:0] fn_oe_n,
   output logic [PPX_NFUNC-1:0] fn_in,
   // Comparator
   input wire logic cmp_raw,
   output logic cmp_sync_out,
   output logic cmp_raw_out,
   // Comparator routing: function slot that carries the comparator output
   input wire logic [PPX_NFUNC-1:0] cmp_sync_slot,
   input wire logic [PPX_NFUNC-1:0] cmp_raw_slot,
   // General-purpose I/O
   input wire logic [PPX_NPINS-1:0] gpio_out,
   input wire logic [PPX_NPINS-1:0] gpio_oe_n,
   output logic [PPX_NPINS-1:0] gpio_in,
   // Pins
   input wire logic [PPX_NPINS-1:0] pin_in,
   output logic [PPX_NPINS-1:0] pin_out,
   output logic [PPX_NPINS-1:0] pin_oe_n,
   // Interrupt
   output logic irq
);
   logic [31:0] ctrl_q;
   logic [31:0] fen_q;
   logic [31:0] skip_q;
   logic [31:0] mask_q;
   logic irq_rd;
   logic [PPX_NPINS-1:0][3:0] pin_sel;
   logic [PPX_NFUNC-1:0] fn_placed;
   logic [PPX_NPINS-1:0] pin_s1_q;
   logic [PPX_NPINS-1:0] pin_s2_q;
   logic cmp_s1_q;
   logic cmp_s2_q;
   logic cmp_prev_q;
   logic [2:0] irq_q;
   logic [2:0] irq_set;
   logic [PPX_NFUNC-1:0] placed_prev_q;
   logic [PPX_NFUNC-1:0] fn_drv;
   logic [PPX_NFUNC-1:0] fn_drv_oe_n;
   logic cmp_en;
   logic cmp_sync_q;

   ppx_apb_regs u_regs (
      .mclk(mclk),
      .rstn(rstn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .ctrl_q(ctrl_q),
      .fen_q(fen_q),
      .skip_q(skip_q),
      .mask_q(mask_q),
      .stat_in({22'h0, fn_placed, cmp_en, cmp_s2_q}),
      .irq_in({29'h0, irq_q}),
      .map_in({24'h0, fn_placed}),
      .irq_rd(irq_rd)
   );

   // Combinational placement follows the register values at once
   ppx_prio_place u_place (
      .uart_en(ctrl_q[PPX_CTRL_UART]),
      .fn_en(fen_q[PPX_NFUNC-1:0]),
      .skip(skip_q[PPX_NPINS-1:0]),
      .pin_sel(pin_sel),
      .fn_placed(fn_placed)
   );

   assign cmp_en = ctrl_q[PPX_CTRL_CMPEN];

   // Pin and comparator synchronisers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
         cmp_s1_q <= cmp_raw;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   // Latched comparator output, forced low while disabled
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) cmp_sync_q <= 1'b0;
      else cmp_sync_q <= cmp_en & cmp_s2_q;
   end
   assign cmp_sync_out = cmp_sync_q;
   // Raw path is pure gating so it keeps working with the clock stopped
   assign cmp_raw_out = cmp_raw & cmp_en;

   // Comparator slots replace the peripheral drive of that function
   always_comb begin
      for (int f = 0; f < PPX_NFUNC; f++) begin
         if (cmp_raw_slot[f]) begin
            fn_drv[f] = cmp_raw_out;
            fn_drv_oe_n[f] = !ctrl_q[PPX_CTRL_RAW_PP] && cmp_raw_out;
         end else if (cmp_sync_slot[f]) begin
            fn_drv[f] = cmp_sync_q;
            fn_drv_oe_n[f] = !ctrl_q[PPX_CTRL_SYNC_PP] && cmp_sync_q;
         end else begin
            fn_drv[f] = fn_out[f];
            fn_drv_oe_n[f] = fn_oe_n[f];
         end
      end
   end

   // Pin output mux; unclaimed pins keep GPIO control
   generate
      for (genvar p = 0; p < PPX_NPINS; p++) begin : g_pin
         always_comb begin
            if (pin_sel[p] == PPX_SEL_GPIO) begin
               pin_out[p] = gpio_out[p];
               pin_oe_n[p] = gpio_oe_n[p];
            end else if (pin_sel[p] == PPX_SEL_TX) begin
               pin_out[p] = ser_tx;
               pin_oe_n[p] = 1'b0;
            end else if (pin_sel[p] == PPX_SEL_RX) begin
               pin_out[p] = 1'b1;
               pin_oe_n[p] = 1'b1;
            end else begin
               pin_out[p] = fn_drv[3'(pin_sel[p] - PPX_SEL_FN0)];
               pin_oe_n[p] = fn_drv_oe_n[3'(pin_sel[p] - PPX_SEL_FN0)];
            end
         end
         assign gpio_in[p] = pin_s2_q[p];
      end
   endgenerate

   // Inputs back to functions; an unplaced function reads idle high
   always_comb begin
      ser_rx = 1'b1;
      fn_in = '1;
      for (int p = 0; p < PPX_NPINS; p++) begin
         if (pin_sel[p] == PPX_SEL_RX) ser_rx = pin_s2_q[p];
         for (int f = 0; f < PPX_NFUNC; f++) begin
            if (pin_sel[p] == PPX_SEL_FN0 + 4'(f)) fn_in[f] = pin_s2_q[p];
         end
      end
   end

   // Comparator edge and lost-placement events
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmp_prev_q <= 1'b0;
         placed_prev_q <= '0;
      end else begin
         cmp_prev_q <= cmp_s2_q & cmp_en;
         placed_prev_q <= fn_placed;
      end
   end
   assign irq_set[PPX_IRQ_RISE] = cmp_en && cmp_s2_q && !cmp_prev_q;
   assign irq_set[PPX_IRQ_FALL] = cmp_prev_q && !(cmp_s2_q && cmp_en);
   assign irq_set[PPX_IRQ_LOST] = |(placed_prev_q & ~fn_placed & fen_q[PPX_NFUNC-1:0]);

   // Sticky status, read clears, a new event wins over the clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) irq_q <= 3'h0;
      else irq_q <= (irq_rd ? 3'h0 : irq_q) | irq_set;
   end
   assign irq = |(irq_q & mask_q[2:0]);

   a_cmp_off_low: assert property (@(posedge mclk) disable iff (!rstn)
      !cmp_en |=> !cmp_sync_out) else $error("sync output not low while off");
   a_raw_gate: assert property (@(posedge mclk) disable iff (!rstn)
      !cmp_en |-> !cmp_raw_out) else $error("raw output not low while off");
   a_uart_pins: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl_q[PPX_CTRL_UART] |-> pin_sel[4] == PPX_SEL_TX && pin_sel[5] == PPX_SEL_RX)
      else $error("serial port not on pins 4 and 5");
   a_skip_honoured: assert property (@(posedge mclk) disable iff (!rstn)
      (skip_q[0] && skip_q[1]) |-> pin_sel[0] == PPX_SEL_GPIO && pin_sel[1] == PPX_SEL_GPIO)
      else $error("function placed on skipped pin");
   a_first_free: assert property (@(posedge mclk) disable iff (!rstn)
      (fen_q[0] && !skip_q[0]) |-> pin_sel[0] == PPX_SEL_FN0)
      else $error("top function not on lowest free pin");
   a_second_next: assert property (@(posedge mclk) disable iff (!rstn)
      (fen_q[1:0] == 2'h3 && skip_q[1:0] == 2'h0 && !ctrl_q[PPX_CTRL_UART])
      |-> pin_sel[1] == PPX_SEL_FN0 + 4'h1) else $error("taken pin not passed over");
   a_idle_gpio: assert property (@(posedge mclk) disable iff (!rstn)
      (fen_q == 32'h0 && !ctrl_q[PPX_CTRL_UART]) |-> pin_out == gpio_out)
      else $error("unclaimed pin not under GPIO");
   a_sync_lag: assert property (@(posedge mclk) disable iff (!rstn)
      (cmp_en && $rose(cmp_s1_q)) ##1 cmp_en |=> cmp_sync_out)
      else $error("latched output did not follow");
   a_irq_sets: assert property (@(posedge mclk) disable iff (!rstn)
      irq_set[PPX_IRQ_RISE] |=> irq_q[PPX_IRQ_RISE]) else $error("rise event lost");

   // Comparator level as seen by the event logic
   sequence s_cmp_on_high;
      cmp_en && cmp_s2_q;
   endsequence
   sequence s_cmp_drop;
      !(cmp_en && cmp_s2_q);
   endsequence

   a_rise_event: assert property (@(posedge mclk) disable iff (!rstn)
      s_cmp_drop ##1 s_cmp_on_high |=> irq_q[PPX_IRQ_RISE])
      else $error("comparator rise not recorded");
   a_fall_event: assert property (@(posedge mclk) disable iff (!rstn)
      s_cmp_on_high ##1 s_cmp_drop |=> irq_q[PPX_IRQ_FALL])
      else $error("comparator fall not recorded");
   a_read_clear: assert property (@(posedge mclk) disable iff (!rstn)
      (irq_rd && irq_set == 3'h0) |=> irq_q == 3'h0)
      else $error("status read did not clear");
   a_lost_event: assert property (@(posedge mclk) disable iff (!rstn)
      irq_set[PPX_IRQ_LOST] |=> irq_q[PPX_IRQ_LOST])
      else $error("lost placement not recorded");
   a_raw_follow: assert property (@(posedge mclk) disable iff (!rstn)
      cmp_en |-> cmp_raw_out == cmp_raw)
      else $error("raw output does not follow comparator");
   a_rx_idle: assert property (@(posedge mclk) disable iff (!rstn)
      !ctrl_q[PPX_CTRL_UART] |-> ser_rx)
      else $error("serial receive not idle while disabled");
   a_tx_drive: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl_q[PPX_CTRL_UART] |-> pin_out[4] == ser_tx && !pin_oe_n[4])
      else $error("serial transmit not driven on pin 4");
   a_unplaced_idle: assert property (@(posedge mclk) disable iff (!rstn)
      !fn_placed[0] |-> fn_in[0])
      else $error("unplaced function input not idle");
   a_rank_keep: assert property (@(posedge mclk) disable iff (!rstn)
      (fen_q[0] && !skip_q[0]) |-> fn_placed[0])
      else $error("top function lost its pin");
   a_raw_od: assert property (@(posedge mclk) disable iff (!rstn)
      (cmp_raw_slot[0] && !ctrl_q[PPX_CTRL_RAW_PP] && cmp_raw_out
      && pin_sel[0] == PPX_SEL_FN0) |-> pin_oe_n[0])
      else $error("open-drain pin driven high");
   a_raw_pp: assert property (@(posedge mclk) disable iff (!rstn)
      (cmp_raw_slot[0] && ctrl_q[PPX_CTRL_RAW_PP] && pin_sel[0] == PPX_SEL_FN0)
      |-> !pin_oe_n[0] && pin_out[0] == cmp_raw_out)
      else $error("push-pull pin not driven");
   a_off_pin_low: assert property (@(posedge mclk) disable iff (!rstn)
      (!cmp_en && cmp_raw_slot[0] && pin_sel[0] == PPX_SEL_FN0) |-> !pin_out[0])
      else $error("routed pin not low while comparator off");
endmodule

// ===== rtl/ppx_pkg.sv
package ppx_pkg;
   // Pin and function geometry
   localparam int PPX_NPINS = 16;
   localparam int PPX_NFUNC = 8;
   localparam int PPX_PINW = 4;
   // Fixed serial port pins
   localparam logic [PPX_PINW-1:0] PPX_TX_PIN = 4'h4;
   localparam logic [PPX_PINW-1:0] PPX_RX_PIN = 4'h5;
   // Function output select codes
   localparam logic [3:0] PPX_SEL_GPIO = 4'h0;
   localparam logic [3:0] PPX_SEL_TX = 4'h1;
   localparam logic [3:0] PPX_SEL_RX = 4'h2;
   localparam logic [3:0] PPX_SEL_FN0 = 4'h3;
   // Register byte offsets
   localparam logic [7:0] PPX_OFS_CTRL = 8'h00;
   localparam logic [7:0] PPX_OFS_FEN = 8'h04;
   localparam logic [7:0] PPX_OFS_SKIP = 8'h08;
   localparam logic [7:0] PPX_OFS_STAT = 8'h0c;
   localparam logic [7:0] PPX_OFS_IRQ = 8'h10;
   localparam logic [7:0] PPX_OFS_MASK = 8'h14;
   localparam logic [7:0] PPX_OFS_MAP0 = 8'h20;
   // Control register bits
   localparam int PPX_CTRL_UART = 0;
   localparam int PPX_CTRL_CMPEN = 1;
   localparam int PPX_CTRL_SYNC_PP = 2;
   localparam int PPX_CTRL_RAW_PP = 3;
   // Interrupt bits
   localparam int PPX_IRQ_RISE = 0;
   localparam int PPX_IRQ_FALL = 1;
   localparam int PPX_IRQ_LOST = 2;
   // Reset values
   localparam logic [31:0] PPX_RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] PPX_RST_SKIP = 32'h0000_0000;
   localparam logic [31:0] PPX_RST_FEN = 32'h0000_0000;
   localparam logic [31:0] PPX_RST_MASK = 32'h0000_0000;
endpackage

// ===== rtl/ppx_prio_place.sv
`timescale 1ns/1ps
module ppx_prio_place
   import ppx_pkg::*;
(
   // Requests
   input wire logic uart_en,
   input wire logic [PPX_NFUNC-1:0] fn_en,
   input wire logic [PPX_NPINS-1:0] skip,
   // Placement
   output logic [PPX_NPINS-1:0][3:0] pin_sel,
   output logic [PPX_NFUNC-1:0] fn_placed
);
   logic [PPX_NPINS-1:0] taken;

   always_comb begin
      taken = skip;
      pin_sel = '0;
      fn_placed = '0;
      // Serial port first, at its fixed pins
      if (uart_en) begin
         pin_sel[PPX_TX_PIN] = PPX_SEL_TX;
         pin_sel[PPX_RX_PIN] = PPX_SEL_RX;
         taken[PPX_TX_PIN] = 1'b1;
         taken[PPX_RX_PIN] = 1'b1;
      end
      // Remaining functions by rank, lowest free pin each
      for (int f = 0; f < PPX_NFUNC; f++) begin
         if (fn_en[f]) begin
            for (int p = 0; p < PPX_NPINS; p++) begin
               if (!fn_placed[f] && !taken[p]) begin
                  pin_sel[p] = PPX_SEL_FN0 + 4'(f);
                  taken[p] = 1'b1;
                  fn_placed[f] = 1'b1;
               end
            end
         end
      end
   end
endmodule

// ===== tb/ppx_pin_model.sv
`timescale 1ns/1ps
module ppx_pin_model
   import ppx_pkg::*;
(
   // Pin side of the crossbar
   input wire logic [PPX_NPINS-1:0] pin_out,
   input wire logic [PPX_NPINS-1:0] pin_oe_n,
   output logic [PPX_NPINS-1:0] pin_in
);
   // Released pins float high through the board pull-up, driven pins loop back
   assign pin_in = (pin_out & ~pin_oe_n) | pin_oe_n;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench
   import ppx_pkg::*;
;
   logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ser_tx = 1'b1, ser_rx, cmp_raw = 1'b0, cmp_sync_out, cmp_raw_out, irq;
   logic [PPX_NFUNC-1:0] fn_out = 8'h05, fn_oe_n = 8'h00, fn_in;
   logic [PPX_NFUNC-1:0] cmp_sync_slot = 8'h00, cmp_raw_slot = 8'h00;
   logic [PPX_NPINS-1:0] gpio_out = 16'h0000, gpio_oe_n = 16'h0000, gpio_in;
   logic [PPX_NPINS-1:0] pin_in, pin_out, pin_oe_n;
   int error_cnt = 0, total_checks = 0;
   logic err;

   always #25 mclk = ~mclk;

   ppx_crossbar i_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ser_tx(ser_tx), .ser_rx(ser_rx), .fn_out(fn_out),
      .fn_oe_n(fn_oe_n), .fn_in(fn_in), .cmp_raw(cmp_raw), .cmp_sync_out(cmp_sync_out),
      .cmp_raw_out(cmp_raw_out), .cmp_sync_slot(cmp_sync_slot), .cmp_raw_slot(cmp_raw_slot),
      .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));

   ppx_pin_model i_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_reset_regs();
      logic [7:0] ofs[4];
      ofs = '{PPX_OFS_CTRL, PPX_OFS_FEN, PPX_OFS_SKIP, PPX_OFS_MASK};
      foreach (ofs[i]) begin
         apb(1'b0, ofs[i], 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 8'h3c, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      $display("test reset_regs done");
   endtask

   task automatic t_comparator();
      cmp_raw_slot <= 8'h01;
      apb(1'b1, PPX_OFS_FEN, 32'h1);
      apb(1'b1, PPX_OFS_MASK, 32'h1);
      apb(1'b1, PPX_OFS_CTRL, 32'ha);
      @(posedge mclk);
      cmp_raw <= 1'b1;
      #5;
      chk({cmp_raw_out, pin_out[0], pin_oe_n[0]}, 32'h6);
      chk({31'h0, cmp_sync_out}, 32'h0);
      repeat (4) @(posedge mclk);
      #1;
      chk({cmp_sync_out, irq}, 32'h3);
      apb(1'b1, PPX_OFS_CTRL, 32'h2);
      #1;
      chk({31'h0, pin_oe_n[0]}, 32'h1);
      apb(1'b0, PPX_OFS_STAT, 32'h0);
      chk(rd & 32'h3, 32'h3);
      apb(1'b0, PPX_OFS_IRQ, 32'h0);
      chk(rd & 32'h1, 32'h1);
      cmp_sync_slot <= 8'h01;
      cmp_raw_slot <= 8'h00;
      @(posedge mclk);
      #1;
      chk({31'h0, irq}, 32'h0);
      chk({30'h0, pin_out[0], pin_oe_n[0]}, 32'h3);
      cmp_sync_slot <= 8'h00;
      cmp_raw_slot <= 8'h01;
      apb(1'b1, PPX_OFS_CTRL, 32'h8);
      #1;
      chk({cmp_raw_out, pin_out[0], pin_oe_n[0]}, 32'h0);
      repeat (2) @(posedge mclk);
      #1;
      chk({31'h0, cmp_sync_out}, 32'h0);
      cmp_raw <= 1'b0;
      cmp_raw_slot <= 8'h00;
      $display("test comparator done");
   endtask

   task automatic t_placement();
      apb(1'b1, PPX_OFS_SKIP, 32'h1);
      apb(1'b1, PPX_OFS_CTRL, 32'h1);
      apb(1'b1, PPX_OFS_FEN, 32'h7);
      #1;
      chk({28'h0, pin_out[3:0]}, 32'ha);
      chk({30'h0, pin_out[4], pin_oe_n[5]}, 32'h3);
      chk({31'h0, pin_out[6] ^ gpio_out[6]}, 32'h0);
      repeat (3) @(posedge mclk);
      chk({29'h0, fn_in[2:0]}, 32'h5);
      chk({31'h0, ser_rx}, 32'h1);
      chk({31'h0, gpio_in[6]}, 32'h0);
      apb(1'b0, PPX_OFS_MAP0, 32'h0);
      chk(rd, 32'h7);
      $display("test placement done");
   endtask

   task automatic t_overflow();
      gpio_out <= 16'h8000;
      apb(1'b1, PPX_OFS_SKIP, 32'hffc0);
      apb(1'b1, PPX_OFS_FEN, 32'hff);
      #1;
      chk({28'h0, pin_out[3:0]}, 32'h5);
      chk({31'h0, pin_out[15]}, 32'h1);
      apb(1'b0, PPX_OFS_MAP0, 32'h0);
      chk(rd, 32'h0f);
      repeat (3) @(posedge mclk);
      chk({31'h0, fn_in[7]}, 32'h1);
      apb(1'b1, PPX_OFS_SKIP, 32'hffc1);
      apb(1'b0, PPX_OFS_MAP0, 32'h0);
      chk(rd, 32'h07);
      apb(1'b0, PPX_OFS_IRQ, 32'h0);
      chk(rd & 32'h7, 32'h6);
      $display("test overflow done");
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      t_reset_regs();
      t_comparator();
      t_placement();
      t_overflow();
      conclude();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk);
      error_cnt++;
      conclude();
   end
endmodule
